/* rtl/mmd_top.sv */
// Memory mapping decode control: holds the mapping control, base and
// family identity registers and decides which I/O and memory cycles the
// device claims for its configuration registers.
// Assumes the LPC front end hands over decoded cycles on clk_sys_in and
// that reset_in is the main-supply power-up reset.
`timescale 1ns/1ps

module mmd_top
#(
    parameter logic [7:0] FAMILY_ID = mmd_pkg::FAMILY_ID_DEFAULT
)
(
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Configuration access through the index/data port pair
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_index_in,
    input wire logic [7:0] cfg_wdata_in,
    output logic cfg_ack_out,
    output logic [7:0] cfg_rdata_out,
    // I/O cycle claim
    input wire logic io_valid_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_pair_high_in,
    input wire logic io_runtime_hit_in,
    output logic io_claim_out,
    output logic io_blocked_out,
    // Memory cycle claim
    input wire logic mem_valid_in,
    input wire logic mem_write_in,
    input wire logic mem_hub_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [3:0] mem_idsel_in,
    input wire logic [7:0] mem_wdata_in,
    output logic mem_claim_out,
    output logic mem_ctrl_out,
    output logic mem_ldev_out,
    output logic [7:0] mem_index_out,
    output logic [7:0] mem_rdata_out
);
    import mmd_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic map_en_r;
    logic lock_r;
    logic io_dis_r;
    logic ldev_en_r;
    logic ctrl_en_r;
    logic [7:0] base_low_r;
    logic [7:0] base_high_r;

    logic map_en_nxt;
    logic lock_nxt;
    logic io_dis_nxt;
    logic ldev_en_nxt;
    logic ctrl_en_nxt;
    logic [7:0] base_low_nxt;
    logic [7:0] base_high_nxt;

    logic cfg_ack_r;
    logic [7:0] cfg_rdata_r;
    logic io_claim_r;
    logic mem_claim_r;
    logic mem_ctrl_r;
    logic mem_ldev_r;
    logic [7:0] mem_index_r;
    logic [7:0] mem_rdata_r;

    mmd_map_if map_if ();

    assign map_if.type_sel = base_high_r[TYPE_SEL_BIT];
    assign map_if.hub_field = base_high_r[HUB_FIELD_MSB:HUB_FIELD_LSB];
    assign map_if.base_low = base_low_r;
    assign map_if.base_high = base_high_r[BASE_HIGH_MSB:0];

    // ****************************************
    // Read selection
    // ****************************************
    // Reserved bits 5-3 read as zero
    wire [7:0] ctrl_rd_val = {map_en_r, lock_r, 3'b000, io_dis_r, ldev_en_r, ctrl_en_r};

    // Config port index decode
    wire cfg_sel_ctrl = (cfg_index_in == IDX_MAP_CTRL);
    wire cfg_sel_low = (cfg_index_in == IDX_BASE_LOW);
    wire cfg_sel_high = (cfg_index_in == IDX_BASE_HIGH);
    wire cfg_sel_fid = (cfg_index_in == IDX_FAMILY_ID);
    wire cfg_own = cfg_sel_ctrl || cfg_sel_low || cfg_sel_high || cfg_sel_fid;
    wire [7:0] cfg_rd_val = cfg_sel_ctrl ? ctrl_rd_val
        : cfg_sel_low ? base_low_r
        : cfg_sel_high ? base_high_r
        : cfg_sel_fid ? FAMILY_ID
        : 8'h00;

    // Memory window index decode
    wire [7:0] mem_idx = mem_addr_in[7:0];
    wire mem_sel_ctrl = (mem_idx == IDX_MAP_CTRL);
    wire mem_sel_low = (mem_idx == IDX_BASE_LOW);
    wire mem_sel_high = (mem_idx == IDX_BASE_HIGH);
    wire mem_sel_fid = (mem_idx == IDX_FAMILY_ID);
    wire mem_own = mem_sel_ctrl || mem_sel_low || mem_sel_high || mem_sel_fid;
    wire [7:0] mem_rd_val = mem_sel_ctrl ? ctrl_rd_val
        : mem_sel_low ? base_low_r
        : mem_sel_high ? base_high_r
        : mem_sel_fid ? FAMILY_ID
        : 8'h00;

    // ****************************************
    // Mapping decisions
    // ****************************************
    // The disable only bites once every memory path is live, so the host
    // can never lock itself out of the configuration space entirely.
    wire io_off = map_en_r && ldev_en_r && ctrl_en_r && io_dis_r;
    wire ctrl_mem_on = map_en_r && ctrl_en_r;
    wire ldev_mem_on = map_en_r && ldev_en_r;
    // I/O reach to each region survives while the other conditions hold
    wire ctrl_io_ok = !ctrl_mem_on || !io_dis_r || !ldev_en_r;
    wire ldev_io_ok = !ldev_mem_on || !io_dis_r || !ctrl_en_r;

    wire window_low_ok = (mem_addr_in[15:8] == WINDOW_UPPER_ZERO);
    wire idx_in_ctrl = (mem_idx >= CTRL_REGION_LO) && (mem_idx <= CTRL_REGION_HI);
    wire idx_in_ldev = (mem_idx >= LDEV_REGION_LO);
    wire base_hit;

    mmd_mem_match u_match
    (
        .map_if(map_if.user),
        .cyc_hub_in(mem_hub_in),
        .addr_in(mem_addr_in),
        .idsel_in(mem_idsel_in),
        .base_hit_out(base_hit)
    );

    wire mem_go = mem_valid_in && base_hit && window_low_ok;
    wire mem_ctrl_hit = mem_go && idx_in_ctrl && ctrl_mem_on;
    wire mem_ldev_hit = mem_go && idx_in_ldev && ldev_mem_on;
    wire mem_hit = mem_ctrl_hit || mem_ldev_hit;

    // Index/data pair selected by the strap-level input
    wire [15:0] pair_base = io_pair_high_in ? IO_PAIR_HIGH : IO_PAIR_LOW;
    wire pair_hit = (io_addr_in[15:1] == pair_base[15:1]);
    wire io_hit = io_valid_in && !io_off && (pair_hit || io_runtime_hit_in);

    // Our registers all sit in the control region
    wire cfg_io_ok = !io_off && ctrl_io_ok;
    wire io_wr = cfg_wr_in && cfg_io_ok && cfg_own;
    wire io_rd = cfg_rd_in && cfg_io_ok && cfg_own;
    wire mem_wr = mem_ctrl_hit && mem_write_in && mem_own;

    // Both paths share one LPC bus so they cannot truly collide; I/O wins
    wire wr_fire = io_wr || mem_wr;
    wire [7:0] wr_idx = io_wr ? cfg_index_in : mem_idx;
    wire [7:0] wr_data = io_wr ? cfg_wdata_in : mem_wdata_in;

    // ****************************************
    // Register writes
    // ****************************************
    wire wr_ctrl = wr_fire && (wr_idx == IDX_MAP_CTRL) && !lock_r;
    wire wr_low = wr_fire && (wr_idx == IDX_BASE_LOW) && !lock_r;
    wire wr_high = wr_fire && (wr_idx == IDX_BASE_HIGH) && !lock_r;

    // Lock is write-one-to-set; clearing needs a power-up reset
    assign lock_nxt = lock_r || (wr_ctrl && wr_data[MAP_LOCK_BIT]);
    assign map_en_nxt = wr_ctrl ? wr_data[MAP_EN_BIT] : map_en_r;
    assign io_dis_nxt = wr_ctrl ? wr_data[MAP_IODIS_BIT] : io_dis_r;
    assign ldev_en_nxt = wr_ctrl ? wr_data[MAP_LDEV_BIT] : ldev_en_r;
    assign ctrl_en_nxt = wr_ctrl ? wr_data[MAP_CTRL_BIT] : ctrl_en_r;
    assign base_low_nxt = wr_low ? wr_data : base_low_r;
    assign base_high_nxt = wr_high ? wr_data : base_high_r;

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            map_en_r <= MAP_CTRL_RST[MAP_EN_BIT];
            lock_r <= MAP_CTRL_RST[MAP_LOCK_BIT];
            io_dis_r <= MAP_CTRL_RST[MAP_IODIS_BIT];
            ldev_en_r <= MAP_CTRL_RST[MAP_LDEV_BIT];
            ctrl_en_r <= MAP_CTRL_RST[MAP_CTRL_BIT];
        end
        else
        begin
            map_en_r <= map_en_nxt;
            lock_r <= lock_nxt;
            io_dis_r <= io_dis_nxt;
            ldev_en_r <= ldev_en_nxt;
            ctrl_en_r <= ctrl_en_nxt;
        end
    end

    // Base registers stay writable while mapping is live; decoding follows at once
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            base_low_r <= BASE_LOW_RST;
        end
        else
        begin
            base_low_r <= base_low_nxt;
        end
    end

    // Type select and field share one write, so a mode change lands whole
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            base_high_r <= BASE_HIGH_RST;
        end
        else
        begin
            base_high_r <= base_high_nxt;
        end
    end

    // ****************************************
    // Answers
    // ****************************************
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cfg_ack_r <= 1'b0;
        end
        else
        begin
            cfg_ack_r <= io_wr || io_rd;
        end
    end

    // Read data reflects state before any write in the same cycle
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cfg_rdata_r <= 8'h00;
        end
        else
        begin
            cfg_rdata_r <= io_rd ? cfg_rd_val : 8'h00;
        end
    end

    // I/O claims wait one cycle like every other answer, so latency is uniform
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            io_claim_r <= 1'b0;
        end
        else
        begin
            io_claim_r <= io_hit;
        end
    end

    // ****************************************
    // Memory answers
    // ****************************************
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            mem_claim_r <= 1'b0;
            mem_ctrl_r <= 1'b0;
            mem_ldev_r <= 1'b0;
        end
        else
        begin
            mem_claim_r <= mem_hit;
            mem_ctrl_r <= mem_ctrl_hit;
            mem_ldev_r <= mem_ldev_hit;
        end
    end

    // Zero when idle, so the host may merge both read buses without masking
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            mem_index_r <= 8'h00;
            mem_rdata_r <= 8'h00;
        end
        else
        begin
            mem_index_r <= mem_hit ? mem_idx : 8'h00;
            mem_rdata_r <= (mem_ctrl_hit && !mem_write_in) ? mem_rd_val : 8'h00;
        end
    end

    assign cfg_ack_out = cfg_ack_r;
    assign cfg_rdata_out = cfg_rdata_r;
    assign io_claim_out = io_claim_r;
    assign io_blocked_out = io_off;
    assign mem_claim_out = mem_claim_r;
    assign mem_ctrl_out = mem_ctrl_r;
    assign mem_ldev_out = mem_ldev_r;
    assign mem_index_out = mem_index_r;
    assign mem_rdata_out = mem_rdata_r;

endmodule // mmd_top

/* rtl/mmd_pkg.sv */
// Constants for the memory map decode control block: register indexes,
// field positions, reset values and decode region bounds.
// Assumes an 8-bit configuration index space reached by I/O or memory cycles.
//
// Overview of operation
// - Memory decode only while memory_map_enable is 1; it resets to 0.
// - mapping_lock is write-1-to-set; once set, all three mapping registers freeze.
// - io_port_disable stops all I/O claims only when all three enables are 1.
// - logical_device_map_enable with memory mapping exposes indexes 30h-FFh in memory.
// - Logical-device I/O access still works when disable or control mapping is 0.
// - control_reg_map_enable with memory mapping exposes indexes 10h-2Fh in memory.
// - Control-register I/O access still works when disable or device mapping is 0.
// - memory_base_low supplies memory base address bits 23 down to 16.
// - memory_base_high_and_type bits 2-0 supply base address bits 26-24.
// - Base address bit 31 is always 1, confining the window to upper 2 GB.
// - transaction_type_select picks plain memory cycles (0) or firmware-hub cycles (1).
// - In plain mode the 4-bit field supplies base address bits 30-27.
// - In hub mode the field is the answered IDSEL; its bit 0 is bit 27.
// - Read-only family_identity register returns a fixed code; writes are ignored.
package mmd_pkg;

    // ****************************************
    // Register indexes
    // ****************************************
    localparam logic [7:0] IDX_MAP_CTRL = 8'h10;
    localparam logic [7:0] IDX_BASE_LOW = 8'h12;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h13;
    localparam logic [7:0] IDX_FAMILY_ID = 8'h20;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int MAP_EN_BIT = 7;
    localparam int MAP_LOCK_BIT = 6;
    localparam int MAP_IODIS_BIT = 2;
    localparam int MAP_LDEV_BIT = 1;
    localparam int MAP_CTRL_BIT = 0;
    localparam int TYPE_SEL_BIT = 7;
    localparam int HUB_FIELD_MSB = 6;
    localparam int HUB_FIELD_LSB = 3;
    localparam int BASE_HIGH_MSB = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] MAP_CTRL_RST = 8'h00;
    localparam logic [7:0] BASE_LOW_RST = 8'h00;
    localparam logic [7:0] BASE_HIGH_RST = 8'h00;
    // Arbitrary neutral value, not a real family code
    localparam logic [7:0] FAMILY_ID_DEFAULT = 8'h5A;

    // ****************************************
    // Decode regions and fixed address bits
    // ****************************************
    localparam logic [7:0] CTRL_REGION_LO = 8'h10;
    localparam logic [7:0] CTRL_REGION_HI = 8'h2F;
    localparam logic [7:0] LDEV_REGION_LO = 8'h30;
    localparam logic [15:0] IO_PAIR_LOW = 16'h002E;
    localparam logic [15:0] IO_PAIR_HIGH = 16'h004E;
    localparam logic [7:0] WINDOW_UPPER_ZERO = 8'h00;

    typedef enum logic
    {
        MMD_CYC_MEM = 1'b0,
        MMD_CYC_HUB = 1'b1
    } mmd_cyc_t;

endpackage

/* rtl/mmd_map_if.sv */
// Carrier for the live mapping configuration from the register bank
// to the memory address matcher. Both ends share one clock domain.
`timescale 1ns/1ps

interface mmd_map_if;
    logic type_sel;
    logic [3:0] hub_field;
    logic [7:0] base_low;
    logic [2:0] base_high;

    modport owner (output type_sel, output hub_field, output base_low, output base_high);
    modport user (input type_sel, input hub_field, input base_low, input base_high);
endinterface

/* rtl/mmd_mem_match.sv */
// Memory window matcher: assembles the base address and compares it
// with an incoming memory or firmware-hub cycle.
// Assumes cycle fields are stable while the valid strobe is high.
`timescale 1ns/1ps

module mmd_mem_match
(
    mmd_map_if.user map_if,
    input wire logic cyc_hub_in,
    input wire logic [31:0] addr_in,
    input wire logic [3:0] idsel_in,
    output logic base_hit_out
);
    import mmd_pkg::*;

    logic [15:0] base_plain;
    logic [15:0] base_hub;
    logic plain_hit;
    logic hub_hit;
    logic type_ok;

    // ****************************************
    // Base assembly
    // ****************************************
    // Bit 31 forced high in both modes
    assign base_plain = {1'b1, map_if.hub_field, map_if.base_high, map_if.base_low};
    assign base_hub = {1'b1, 3'b000, map_if.hub_field[0], map_if.base_high, map_if.base_low};

    // Hub cycles carry bits 30-28 nowhere in the base, so they are not compared
    assign plain_hit = (addr_in[31:16] == base_plain);
    assign hub_hit = (addr_in[31] == base_hub[15])
        && (addr_in[27:16] == base_hub[11:0])
        && (idsel_in == map_if.hub_field);

    assign type_ok = (cyc_hub_in == map_if.type_sel);
    assign base_hit_out = type_ok && (map_if.type_sel == MMD_CYC_HUB ? hub_hit : plain_hit);

endmodule // mmd_mem_match

/* verif/mmd_top_asserts.sv */
// Port checker for mmd_top, attached by bind at the foot of this file.
// Assumes one clock domain and an active-high asynchronous reset_in.
`timescale 1ns/1ps

module mmd_top_asserts
#(
    parameter logic [7:0] FAMILY_ID = 8'h00
)
(
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_index_in,
    input wire logic cfg_ack_out,
    input wire logic [7:0] cfg_rdata_out,
    input wire logic io_valid_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_pair_high_in,
    input wire logic io_runtime_hit_in,
    input wire logic io_claim_out,
    input wire logic io_blocked_out,
    input wire logic mem_valid_in,
    input wire logic mem_hub_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [3:0] mem_idsel_in,
    input wire logic mem_claim_out,
    input wire logic mem_ctrl_out,
    input wire logic mem_ldev_out,
    input wire logic [7:0] mem_index_out
);
    import mmd_pkg::*;
    wire logic cfg_req = cfg_wr_in || cfg_rd_in;
    wire logic own_idx = cfg_index_in inside
        {IDX_MAP_CTRL, IDX_BASE_LOW, IDX_BASE_HIGH, IDX_FAMILY_ID};
    wire logic cfg_ok = cfg_req && own_idx && !io_blocked_out;
    wire logic [15:0] pair = io_pair_high_in ? IO_PAIR_HIGH : IO_PAIR_LOW;
    // Only bit 0 of the port address may differ inside the selected pair
    wire logic io_hit = io_addr_in[15:1] == pair[15:1] || io_runtime_hit_in;
    // ********
    // Assertions
    // ********
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    cfg_ack_due_a: assert property (cfg_ok |=> cfg_ack_out)
        else $error("config access not acknowledged");
    cfg_refused_a: assert property (cfg_req && io_blocked_out |=> !cfg_ack_out)
        else $error("config access acknowledged while blocked");
    family_code_a: assert property (cfg_ok && cfg_rd_in && cfg_index_in == IDX_FAMILY_ID
        ##1 cfg_ack_out |-> cfg_rdata_out == FAMILY_ID) else $error("wrong family code");
    io_claim_due_a: assert property (io_valid_in && !io_blocked_out && io_hit |=> io_claim_out)
        else $error("io cycle not claimed");
    io_blocked_a: assert property (io_valid_in && io_blocked_out |=> !io_claim_out)
        else $error("io cycle claimed while blocked");
    mem_upper_a: assert property (mem_valid_in && !mem_addr_in[31] |=> !mem_claim_out)
        else $error("claim below upper half");
    mem_offset_a: assert property (mem_valid_in && mem_addr_in[15:8] != 8'h00 |=>
        !mem_claim_out) else $error("claim outside window");
    mem_region_a: assert property (mem_claim_out |-> mem_index_out >= CTRL_REGION_LO &&
        mem_ctrl_out == (mem_index_out <= CTRL_REGION_HI) &&
        mem_ldev_out == (mem_index_out >= LDEV_REGION_LO)) else $error("wrong region flags");
    hub_idsel_a: assert property (mem_valid_in && mem_hub_in &&
        mem_idsel_in[0] != mem_addr_in[27] |=> !mem_claim_out) else $error("bad hub claim");
    cover property (mem_claim_out && mem_ldev_out);
    cover property (io_valid_in && io_blocked_out);
    cover property (mem_valid_in && mem_hub_in ##1 mem_claim_out);
endmodule // mmd_top_asserts

bind mmd_top mmd_top_asserts #(.FAMILY_ID(FAMILY_ID)) i_mmd_top_asserts (.*);

/* verif/mmd_host_model.sv */
// Host bus controller model: issues config, I/O and memory cycles.
// Assumes one caller at a time; every request stands for one clock edge.
`timescale 1ns/1ps

module mmd_host_model
(
    input wire logic clk_sys_in,
    output logic cfg_wr_in,
    output logic cfg_rd_in,
    output logic [7:0] cfg_index_in,
    output logic [7:0] cfg_wdata_in,
    output logic io_valid_in,
    output logic [15:0] io_addr_in,
    output logic io_pair_high_in,
    output logic io_runtime_hit_in,
    output logic mem_valid_in,
    output logic mem_write_in,
    output logic mem_hub_in,
    output logic [31:0] mem_addr_in,
    output logic [3:0] mem_idsel_in,
    output logic [7:0] mem_wdata_in
);
    // ********
    // Cycle driver
    // ********
    initial
    begin
        {cfg_wr_in, cfg_rd_in, io_valid_in, mem_valid_in, mem_write_in, mem_hub_in} = '0;
        {io_pair_high_in, io_runtime_hit_in, cfg_index_in, cfg_wdata_in} = '0;
        {io_addr_in, mem_addr_in, mem_idsel_in, mem_wdata_in} = '0;
    end

    task automatic drive(input int kind, input logic wr, input logic [1:0] lv,
        input logic [31:0] addr, input logic [3:0] ids, input logic [7:0] data);
        @(posedge clk_sys_in);
        #1;
        cfg_wr_in = kind == 0 && wr;
        cfg_rd_in = kind == 0 && !wr;
        io_valid_in = kind == 1;
        mem_valid_in = kind == 2;
        mem_write_in = wr;
        {mem_hub_in, io_runtime_hit_in, io_pair_high_in} = {lv[0], lv[0], lv[1]};
        {cfg_index_in, io_addr_in, mem_addr_in} = {addr[7:0], addr[15:0], addr};
        {mem_idsel_in, cfg_wdata_in, mem_wdata_in} = {ids, data, data};
        @(posedge clk_sys_in);
        #1;
        {cfg_wr_in, cfg_rd_in, io_valid_in, mem_valid_in} = '0;
        // Released lines toggle so a stale value is never mistaken for a live one
        {cfg_index_in, io_addr_in, mem_addr_in} = ~{cfg_index_in, io_addr_in, mem_addr_in};
        {mem_idsel_in, cfg_wdata_in, mem_wdata_in} = ~{mem_idsel_in, cfg_wdata_in, mem_wdata_in};
    endtask
endmodule // mmd_host_model

/* verif/mmd_top_bench.sv */
// Self-checking bench for mmd_top driven by the host model.
// Assumes each accepted request is answered one clock later.
`timescale 1ns/1ps

module mmd_top_bench;
    import mmd_pkg::*;
    // Arbitrary family code for this run
    localparam logic [7:0] FID = 8'h6B;
    localparam logic [23:0] ACK = 24'h80_0000;
    localparam logic [23:0] IOC = 24'h40_0000;
    localparam logic [23:0] MC = 24'h30_0000;
    localparam logic [23:0] ML = 24'h28_0000;
    logic clk_sys_in;
    logic reset_in;
    wire logic cfg_wr_in, cfg_rd_in, io_valid_in, io_pair_high_in, io_runtime_hit_in;
    wire logic mem_valid_in, mem_write_in, mem_hub_in, cfg_ack_out, io_claim_out;
    wire logic io_blocked_out, mem_claim_out, mem_ctrl_out, mem_ldev_out;
    wire logic [7:0] cfg_index_in, cfg_wdata_in, mem_wdata_in, cfg_rdata_out;
    wire logic [7:0] mem_index_out, mem_rdata_out;
    wire logic [15:0] io_addr_in;
    wire logic [31:0] mem_addr_in;
    wire logic [3:0] mem_idsel_in;
    wire logic [23:0] seen = {cfg_ack_out, io_claim_out, mem_claim_out, mem_ctrl_out,
        mem_ldev_out, 3'b000, mem_index_out, cfg_rdata_out | mem_rdata_out};
    logic [23:0] notes[$];
    logic [7:0] lo;
    logic [7:0] hi;
    int miscompares = 0;
    int compares = 0;

    mmd_top #(.FAMILY_ID(FID)) i_mmd_top (.*);
    mmd_host_model i_mmd_host_model (.*);

    // ********
    // Helpers
    // ********
    function automatic logic [31:0] madr(input logic [7:0] idx);
        return {1'b1, hi[6:0], lo, 8'h00, idx};
    endfunction

    // Hub cycles leave address bits 30-28 free, so they are randomised
    function automatic logic [31:0] hadr(input logic [7:0] idx);
        return {1'b1, 3'($urandom), hi[3:0], lo, 8'h00, idx};
    endfunction

    task automatic check(input logic [23:0] seen_v, input logic [23:0] exp_v);
        compares++;
        if (seen_v !== exp_v)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic print_verdict;
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A zero note means the request must not be answered
    task automatic op(input int kind, input logic wr, input logic [1:0] lv,
        input logic [31:0] addr, input logic [3:0] ids, input logic [7:0] data,
        input logic [23:0] note);
        if (note != 24'h00_0000)
            notes.push_back(note);
        i_mmd_host_model.drive(kind, wr, lv, addr, ids, data);
    endtask

    always @(negedge clk_sys_in)
    begin
        if (cfg_ack_out !== 1'b0 || io_claim_out !== 1'b0 || mem_claim_out !== 1'b0)
            check(seen, notes.size() != 0 ? notes.pop_front() : 24'h00_0000);
    end

    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    initial
    begin
        reset_in = 1'b1;
        {lo, hi} = 16'h0000;
        void'($urandom(3));
        repeat (6) @(posedge clk_sys_in);
        #1;
        reset_in = 1'b0;
        op(0, 0, 0, IDX_MAP_CTRL, 0, 0, ACK);
        op(0, 0, 0, IDX_FAMILY_ID, 0, 0, ACK | FID);
        op(0, 1, 0, IDX_FAMILY_ID, 0, 8'h00, ACK);
        op(0, 0, 0, IDX_FAMILY_ID, 0, 0, ACK | FID);
        op(0, 0, 0, 8'h11, 0, 0, 0);
        op(2, 0, 0, madr(8'h10), 0, 0, 0);
        lo = 8'($urandom);
        hi = {1'b0, 7'($urandom)};
        op(0, 1, 0, IDX_BASE_LOW, 0, lo, ACK);
        op(0, 1, 0, IDX_BASE_HIGH, 0, hi, ACK);
        op(0, 1, 0, IDX_MAP_CTRL, 0, 8'h81, ACK);
        op(2, 0, 0, madr(IDX_BASE_LOW), 0, 0, MC | {IDX_BASE_LOW, lo});
        op(2, 0, 0, madr(8'h30), 0, 0, 0);
        op(2, 0, 0, madr(8'h10) ^ 32'h8000_0000, 0, 0, 0);
        op(2, 0, 1, madr(8'h10), hi[6:3], 0, 0);
        op(0, 1, 0, IDX_MAP_CTRL, 0, 8'h83, ACK);
        op(2, 0, 0, madr(8'hA5), 0, 0, ML | 16'hA500);
        op(1, 0, 0, 32'h0000_002F, 0, 0, IOC);
        op(1, 0, 2, 32'h0000_002E, 0, 0, 0);
        op(1, 0, 2, 32'h0000_004F, 0, 0, IOC);
        hi = {1'b1, 7'($urandom)};
        op(0, 1, 0, IDX_BASE_HIGH, 0, hi, ACK);
        op(2, 0, 1, hadr(IDX_BASE_LOW), hi[6:3], 0, MC | {IDX_BASE_LOW, lo});
        op(2, 0, 1, hadr(IDX_BASE_LOW), ~hi[6:3], 0, 0);
        op(2, 0, 0, hadr(IDX_BASE_LOW), hi[6:3], 0, 0);
        op(0, 1, 0, IDX_MAP_CTRL, 0, 8'h87, ACK);
        check({23'h00_0000, io_blocked_out}, 24'h00_0001);
        op(1, 0, 0, 32'h0000_002E, 0, 0, 0);
        op(0, 0, 0, IDX_MAP_CTRL, 0, 0, 0);
        op(2, 1, 1, hadr(IDX_MAP_CTRL), hi[6:3], 8'h85, MC | 16'h1000);
        check({23'h00_0000, io_blocked_out}, 24'h00_0000);
        op(1, 0, 1, 32'h0000_0300, 0, 0, IOC);
        op(0, 0, 0, IDX_MAP_CTRL, 0, 0, ACK | 8'h85);
        op(0, 1, 0, IDX_MAP_CTRL, 0, 8'hC3, ACK);
        op(0, 1, 0, IDX_MAP_CTRL, 0, 8'h00, ACK);
        op(0, 1, 0, IDX_BASE_LOW, 0, ~lo, ACK);
        op(0, 0, 0, IDX_MAP_CTRL, 0, 0, ACK | 8'hC3);
        op(0, 0, 0, IDX_BASE_LOW, 0, 0, ACK | lo);
        // Power-up reset in mid-run must clear the lock and the low base
        @(posedge clk_sys_in);
        #1;
        reset_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        reset_in = 1'b0;
        op(0, 0, 0, IDX_BASE_LOW, 0, 0, ACK | BASE_LOW_RST);
        op(0, 1, 0, IDX_MAP_CTRL, 0, 8'h01, ACK);
        op(0, 0, 0, IDX_MAP_CTRL, 0, 0, ACK | 8'h01);
        for (int i = 0; i < 10 && notes.size() != 0; i++)
            @(posedge clk_sys_in);
        if (notes.size() != 0)
            check(24'h00_0000, notes.pop_front());
        print_verdict();
    end
endmodule // mmd_top_bench
